/* File: rtl/tca_pkg.sv */
// Package for the four-channel timer array: register map, field layout,
// channel modes and the packed state carried by the array.
// Assumes a 32-bit APB register port with an 8-bit byte address.
package tca_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NCH = 4;
   localparam int CW = 16;
   localparam int PRE_W = 15;
   localparam int AW = 8;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] OFF_CH_LAST = 8'h3c;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_DATA = 2'h1;
   localparam logic [1:0] REG_COUNT = 2'h2;
   localparam logic [1:0] REG_CAPT = 2'h3;
   localparam logic [AW-1:0] OFF_STATUS = 8'h40;
   localparam logic [AW-1:0] OFF_CLEAR = 8'h44;
   localparam logic [AW-1:0] OFF_ENABLE = 8'h48;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PRE_LSB = 4;
   localparam int CTRL_EDGE_LSB = 8;
   localparam int CTRL_MSEL_LSB = 10;
   localparam int CTRL_RUN_BIT = 12;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_IDLE, MODE_INTERVAL, MODE_SQUARE, MODE_EVENT, MODE_DIVIDER,
      MODE_PULSE_INT, MODE_LEVEL_WIDTH, MODE_DELAY, MODE_ONESHOT_MASTER,
      MODE_ONESHOT_SLAVE, MODE_PWM_MASTER, MODE_PWM_SLAVE
   } tca_mode_e;

   typedef struct packed {
      logic run;
      logic [1:0] master_sel;
      logic [1:0] edge_sel;
      logic [3:0] pre_sel;
      tca_mode_e mode;
   } tca_ctrl_s;

   typedef struct packed {
      tca_ctrl_s ctrl;
      logic [CW-1:0] data;
      logic [CW-1:0] cnt;
      logic [CW-1:0] capt;
      logic out;
      logic busy;
   } tca_chan_s;

   typedef struct packed {
      tca_chan_s [NCH-1:0] ch;
      logic [PRE_W-1:0] pre;
      logic [NCH-1:0] sync1;
      logic [NCH-1:0] sync2;
      logic [NCH-1:0] prev;
      logic [NCH-1:0] status;
      logic [NCH-1:0] enable;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tca_state_s;

   localparam tca_state_s STATE_RST = '0;

endpackage

/* File: rtl/tca_timer_array.sv */
// Four-channel 16-bit timer array with APB register port and interrupt.
// Assumes pclk is the system clock; timer input pins are asynchronous
// and are synchronised here before use.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module tca_timer_array
   import tca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NCH-1:0] channel_input_pin,
   output logic [NCH-1:0] channel_output_pin,
   output logic channel_timer_interrupt
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One count clock enable per prescaler wrap of the selected width
   function automatic logic count_tick(input logic [PRE_W-1:0] pre, input logic [3:0] sel);
      logic [PRE_W-1:0] mask;
      mask = PRE_W'((16'h0001 << sel) - 16'h0001);
      return (pre & mask) == mask;
   endfunction

   // Edge select: 0 rising, 1 falling, 2 and 3 both; used by event, divider, delay and pulse-interval modes
   function automatic logic valid_edge(input logic rise, input logic fall,
                                       input logic [1:0] sel);
      logic v;
      v = 1'b0;
      unique case (sel)
         2'h0: v = rise;
         2'h1: v = fall;
         default: v = rise | fall;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Word-aligned and inside the map; anything else is refused with pslverr.
   // The same test gates writes, so a refused write can never alias a register.
   function automatic logic addr_ok(input logic [AW-1:0] a);
      return (a[1:0] == 2'h0) && (a <= OFF_ENABLE);
   endfunction

   // Read view of one channel register; unused upper bits read zero
   function automatic logic [31:0] chan_read(input tca_chan_s ch, input logic [1:0] sel);
      logic [31:0] v;
      v = '0;
      unique case (sel)
         REG_CTRL: v = 32'(ch.ctrl);
         REG_DATA: v = 32'(ch.data);
         REG_COUNT: v = 32'(ch.cnt);
         REG_CAPT: v = 32'(ch.capt);
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tca_state_s s_ff;
   tca_state_s nxt_s;

   logic [NCH-1:0] ev;
   logic [NCH-1:0] rise;
   logic [NCH-1:0] fall;
   logic [NCH-1:0] tick;
   logic [NCH-1:0] edg;
   logic [NCH-1:0] clr;
   logic setup;
   logic wr;
   logic [1:0] wch;
   logic [1:0] wreg;
   tca_chan_s c;
   tca_chan_s n;

   always_comb begin
      nxt_s = s_ff;
      ev = '0;
      clr = '0;
      c = s_ff.ch[0];
      n = s_ff.ch[0];
      setup = psel & ~penable;
      // Writes land only at the edge that ends the access cycle
      wr = psel & penable & s_ff.pready & pwrite & addr_ok(paddr);
      wch = paddr[5:4];
      wreg = paddr[3:2];

      // Free-running prescaler and input synchronisers.
      // The prescaler is shared, so a restarted channel keeps no fixed phase to it.
      // Two flops guard against metastability; the third only remembers the last level.
      nxt_s.pre = s_ff.pre + PRE_W'(1);
      nxt_s.sync1 = channel_input_pin;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.prev = s_ff.sync2;
      rise = s_ff.sync2 & ~s_ff.prev;
      fall = ~s_ff.sync2 & s_ff.prev;

      // ----------------------------------------------------------------
      // Stand-alone channels and masters
      // ----------------------------------------------------------------
      for (int i = 0; i < NCH; i++) begin
         c = s_ff.ch[i];
         n = c;
         tick[i] = count_tick(s_ff.pre, c.ctrl.pre_sel);
         edg[i] = valid_edge(rise[i], fall[i], c.ctrl.edge_sel);
         if (c.ctrl.run) begin
            unique case (c.ctrl.mode)
               MODE_INTERVAL, MODE_SQUARE, MODE_PWM_MASTER: begin
                  if (tick[i]) begin
                     if (c.cnt == '0) begin
                        n.cnt = c.data;
                        ev[i] = 1'b1;
                        if (c.ctrl.mode == MODE_SQUARE) begin
                           n.out = ~c.out;
                        end
                     end else begin
                        n.cnt = c.cnt - CW'(1);
                     end
                  end
               end
               MODE_EVENT, MODE_DIVIDER: begin
                  // Divider is not built on the other channels
                  if (edg[i] && (c.ctrl.mode == MODE_EVENT || i == 0)) begin
                     if (c.cnt == '0) begin
                        n.cnt = c.data;
                        ev[i] = 1'b1;
                        if (c.ctrl.mode == MODE_DIVIDER) begin
                           n.out = ~c.out;
                        end
                     end else begin
                        n.cnt = c.cnt - CW'(1);
                     end
                  end
               end
               MODE_PULSE_INT: begin
                  if (edg[i]) begin
                     n.capt = c.cnt;
                     n.cnt = '0;
                     ev[i] = 1'b1;
                  end else if (tick[i]) begin
                     n.cnt = c.cnt + CW'(1);
                  end
               end
               MODE_LEVEL_WIDTH: begin
                  // edge_sel bit 0 set measures the low width
                  if (c.busy) begin
                     if (c.ctrl.edge_sel[0] ? rise[i] : fall[i]) begin
                        n.capt = c.cnt;
                        n.busy = 1'b0;
                        ev[i] = 1'b1;
                     end else if (tick[i]) begin
                        n.cnt = c.cnt + CW'(1);
                     end
                  end else if (c.ctrl.edge_sel[0] ? fall[i] : rise[i]) begin
                     n.cnt = '0;
                     n.busy = 1'b1;
                  end
               end
               MODE_DELAY, MODE_ONESHOT_MASTER: begin
                  // Edges that arrive while a delay runs are ignored
                  if (!c.busy) begin
                     if (edg[i]) begin
                        n.cnt = c.data;
                        n.busy = 1'b1;
                     end
                  end else if (tick[i]) begin
                     if (c.cnt == '0) begin
                        n.busy = 1'b0;
                        ev[i] = 1'b1;
                     end else begin
                        n.cnt = c.cnt - CW'(1);
                     end
                  end
               end
               MODE_IDLE, MODE_ONESHOT_SLAVE, MODE_PWM_SLAVE: begin
               end
               default: begin
               end
            endcase
         end
         nxt_s.ch[i] = n;
      end

      // ----------------------------------------------------------------
      // Slaves follow the event of the master they select
      // ----------------------------------------------------------------
      // Slaves run after the masters so they see this cycle's master event;
      // a slave chained to another slave sees that slave's event only if it has the higher channel number.
      for (int i = 0; i < NCH; i++) begin
         c = s_ff.ch[i];
         n = nxt_s.ch[i];
         if (c.ctrl.run && c.ctrl.mode == MODE_ONESHOT_SLAVE) begin
            if (ev[c.ctrl.master_sel]) begin
               n.cnt = c.data;
               n.out = 1'b1;
               n.busy = 1'b1;
            end else if (c.busy && tick[i]) begin
               if (c.cnt == '0) begin
                  n.out = 1'b0;
                  n.busy = 1'b0;
                  ev[i] = 1'b1;
               end else begin
                  n.cnt = c.cnt - CW'(1);
               end
            end
         end else if (c.ctrl.run && c.ctrl.mode == MODE_PWM_SLAVE) begin
            // Duty is data count clocks; data above the period gives 100 %
            if (ev[c.ctrl.master_sel]) begin
               n.cnt = c.data;
               n.out = (c.data != '0);
               n.busy = (c.data != '0);
            end else if (c.busy && tick[i]) begin
               if (c.cnt == CW'(1)) begin
                  n.out = 1'b0;
                  n.busy = 1'b0;
                  ev[i] = 1'b1;
               end else begin
                  n.cnt = c.cnt - CW'(1);
               end
            end
         end
         nxt_s.ch[i] = n;
      end

      // ----------------------------------------------------------------
      // Register writes, taken in the access cycle
      // ----------------------------------------------------------------
      if (wr) begin
         if (paddr <= OFF_CH_LAST) begin
            if (wreg == REG_CTRL) begin
               nxt_s.ch[wch].ctrl.mode = tca_mode_e'(pwdata[CTRL_MODE_LSB +: 4]);
               nxt_s.ch[wch].ctrl.pre_sel = pwdata[CTRL_PRE_LSB +: 4];
               nxt_s.ch[wch].ctrl.edge_sel = pwdata[CTRL_EDGE_LSB +: 2];
               nxt_s.ch[wch].ctrl.master_sel = pwdata[CTRL_MSEL_LSB +: 2];
               nxt_s.ch[wch].ctrl.run = pwdata[CTRL_RUN_BIT];
               // Every control write restarts the channel from a clean state
               nxt_s.ch[wch].busy = 1'b0;
               nxt_s.ch[wch].out = 1'b0;
               if (pwdata[CTRL_MODE_LSB +: 4] == 4'(MODE_PULSE_INT)) begin
                  nxt_s.ch[wch].cnt = '0;
               end else begin
                  nxt_s.ch[wch].cnt = s_ff.ch[wch].data;
               end
            end else if (wreg == REG_DATA) begin
               nxt_s.ch[wch].data = pwdata[CW-1:0];
            end
         end else if (paddr == OFF_CLEAR) begin
            clr = pwdata[NCH-1:0];
         end else if (paddr == OFF_ENABLE) begin
            nxt_s.enable = pwdata[NCH-1:0];
         end
      end

      // Sticky status: a new event wins over a clear in the same cycle,
      // so software never loses an event that lands on its own clear.
      // The interrupt follows next-state status to save a cycle of latency.
      nxt_s.status = (s_ff.status & ~clr) | ev;
      nxt_s.irq = |(nxt_s.status & nxt_s.enable);

      // ----------------------------------------------------------------
      // Read path and answer, prepared in the setup cycle
      // ----------------------------------------------------------------
      nxt_s.pready = setup;
      // Answer always comes one cycle after setup: no wait states
      nxt_s.pslverr = setup & ~addr_ok(paddr);
      // Read data is zero outside the access cycle, so a stale word is never seen
      nxt_s.prdata = '0;
      if (setup && !pwrite && addr_ok(paddr)) begin
         if (paddr <= OFF_CH_LAST) begin
            nxt_s.prdata = chan_read(s_ff.ch[wch], wreg);
         end else if (paddr == OFF_STATUS) begin
            nxt_s.prdata = 32'(s_ff.status);
         end else if (paddr == OFF_ENABLE) begin
            nxt_s.prdata = 32'(s_ff.enable);
         end
      end
   end

   // All state in one register; reset clears every field, outputs included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= STATE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         channel_output_pin[i] = s_ff.ch[i].out;
      end
   end

   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign channel_timer_interrupt = s_ff.irq;

endmodule // tca_timer_array

/* File: tb/tca_pin_model.sv */
// Signal sources on the timer input pins.
// Assumes tasks are called just after a rising pclk edge.
`timescale 1ns/1ps
module tca_pin_model
   import tca_pkg::*;
(
   input wire logic pclk,
   output logic [NCH-1:0] pin
);
   initial pin = '0;

   // Whole-cycle levels, so the two-flop synchroniser never misses one
   task automatic pulse(input logic [NCH-1:0] m, input int hi, input int lo);
      pin <= pin | m;
      repeat (hi) @(posedge pclk);
      pin <= pin & ~m;
      repeat (lo) @(posedge pclk);
   endtask
endmodule // tca_pin_model

/* File: tb/tca_timer_array_chk.sv */
// Bus and interrupt checker for the timer array.
// Assumes it is bound to tca_timer_array and sees only its ports.
`timescale 1ns/1ps
module tca_chk
   import tca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic channel_timer_interrupt
);
   logic acc;
   assign acc = psel && penable && pready;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ------
   // Bus answer
   // ------
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("answer held too long");
   chk_ready_in_access: assert property (pready |-> psel && penable)
      else $error("answer outside access");
   chk_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   chk_err_range: assert property (acc && paddr > OFF_ENABLE |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= OFF_ENABLE |-> !pslverr)
      else $error("mapped access refused");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   chk_clear_reads_zero: assert property (acc && !pwrite && paddr == OFF_CLEAR |-> prdata == 32'h0)
      else $error("clear register reads nonzero");
   // ------
   // Interrupt
   // ------
   chk_irq_masked: assert property (acc && pwrite && paddr == OFF_ENABLE && pwdata[NCH-1:0] == '0
      |=> ##1 !channel_timer_interrupt)
      else $error("interrupt with all sources masked");
endmodule // tca_chk

bind tca_timer_array tca_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .channel_timer_interrupt(channel_timer_interrupt));

/* File: tb/tb_timer_channel_array.sv */
// Self-checking bench for the timer array: APB master, pin model, checks.
// Assumes one 10 MHz clock; channel k registers sit at 0x10*k.
`timescale 1ns/1ps
module tb_timer_channel_array
   import tca_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, irq;
   logic [NCH-1:0] pin, outp;
   int n_fail = 0;
   int n_tests = 0;
   int d, p, w, k;

   always #50 pclk = ~pclk;

   tca_timer_array uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .channel_input_pin(pin), .channel_output_pin(outp),
      .channel_timer_interrupt(irq));
   tca_pin_model pins (.pclk(pclk), .pin(pin));

   // ------
   // Helpers
   // ------
   task automatic end_sim();
      if (n_fail == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] dat);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n == 50) begin
         n_fail++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] dat);
      apb(1'b1, a, dat);
   endtask

   task automatic rdc(input string nm, input logic [AW-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   function automatic logic [31:0] ctl(tca_mode_e m, int s, int ms);
      return 32'(32'h1000 | (ms << CTRL_MSEL_LSB) | (s << CTRL_PRE_LSB) | m);
   endfunction

   // Width in cycles of the next full stretch of output ch at level v
   task automatic lvl(input int ch, input logic v, output int n);
      int i, t;
      for (i = 0; i < 3000 && outp[ch] !== ~v; i++) @(negedge pclk);
      t = i;
      for (i = 0; i < 3000 && outp[ch] !== v; i++) @(negedge pclk);
      t += i;
      for (n = 0; n < 3000 && outp[ch] === v; n++) @(negedge pclk);
      @(posedge pclk);
      if (t + n >= 3000) begin
         n_fail++;
         end_sim();
      end
   endtask

   // ------
   // Scenarios
   // ------
   initial begin
      void'($urandom(32'he028));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("outputs", 0, {irq, outp});
      rdc("status", OFF_STATUS, 0);
      apb(1'b0, 8'h4c, 0);
      chk("err_rd", 1, er);
      chk("err_data", 0, rd);
      apb(1'b1, 8'h06, 32'h5);
      chk("err_wr", 1, er);
      rdc("data0", 8'h04, 0);
      for (k = 0; k < NCH; k++) begin
         d = $urandom_range(16'hffff);
         wr(8'(16 * k + 4), d);
         wr(8'(16 * k), ctl(MODE_IDLE, 0, 0));
         rdc("data", 8'(16 * k + 4), d);
         rdc("count", 8'(16 * k + 8), d);
      end
      // Prescaler runs free, so only widths are compared, not phase
      for (k = 0; k < 3; k++) begin
         d = $urandom_range(6, 1);
         wr(8'h14, d);
         wr(8'h10, ctl(MODE_SQUARE, k, 0));
         lvl(1, 1'b1, w);
         chk("sq_high", (d + 1) << k, w);
         lvl(1, 1'b0, w);
         chk("sq_low", (d + 1) << k, w);
      end
      wr(8'h10, ctl(MODE_IDLE, 0, 0));
      rdc("status", OFF_STATUS, 32'h2);
      wr(OFF_ENABLE, 32'h2);
      chk("irq_on", 1, irq);
      wr(OFF_ENABLE, 0);
      chk("irq_mask", 0, irq);
      wr(OFF_ENABLE, 32'h2);
      wr(OFF_CLEAR, 32'h2);
      chk("irq_clr", 0, irq);
      rdc("status", OFF_STATUS, 0);
      d = $urandom_range(4, 1);
      wr(8'h24, d);
      wr(8'h20, ctl(MODE_EVENT, 0, 0));
      repeat (d) pins.pulse(4'h4, 3, 3);
      repeat (4) @(posedge pclk);
      rdc("ev_early", OFF_STATUS, 0);
      pins.pulse(4'h4, 3, 3);
      repeat (4) @(posedge pclk);
      rdc("ev_done", OFF_STATUS, 32'h4);
      wr(8'h04, 0);
      wr(8'h00, ctl(MODE_DIVIDER, 0, 0));
      wr(8'h10, ctl(MODE_DIVIDER, 0, 0));
      for (k = 1; k < 5; k++) begin
         pins.pulse(4'h3, 3, 3);
         repeat (4) @(posedge pclk);
         chk("divider", k % 2, outp[1:0]);
      end
      for (k = 0; k < 2; k++) begin
         p = $urandom_range(30, 8);
         wr(8'h30, ctl(k ? MODE_LEVEL_WIDTH : MODE_PULSE_INT, 0, 0));
         repeat (2) pins.pulse(4'h8, k ? p : 2, k ? 4 : p - 2);
         repeat (4) @(posedge pclk);
         apb(1'b0, 8'h3c, 0);
         chk("capture", 1, rd >= p - 1 && rd <= p);
      end
      d = $urandom_range(9, 4);
      w = $urandom_range(12, 1);
      wr(8'h04, d);
      wr(8'h14, w);
      wr(8'h10, ctl(MODE_ONESHOT_SLAVE, 0, 0));
      wr(8'h00, ctl(MODE_ONESHOT_MASTER, 0, 0));
      wr(OFF_CLEAR, 32'hf);
      pins.pulse(4'h1, 2, 2);
      lvl(1, 1'b1, p);
      chk("oneshot", w + 1, p);
      rdc("os_status", OFF_STATUS, 32'h3);
      p = $urandom_range(15, 8);
      d = $urandom_range(p - 1, 1);
      w = $urandom_range(p - 1, 1);
      wr(8'h04, p);
      wr(8'h14, d);
      wr(8'h24, w);
      wr(8'h10, ctl(MODE_PWM_SLAVE, 0, 0));
      wr(8'h20, ctl(MODE_PWM_SLAVE, 0, 0));
      wr(8'h00, ctl(MODE_PWM_MASTER, 0, 0));
      lvl(1, 1'b1, k);
      chk("pwm_duty1", d, k);
      lvl(1, 1'b0, k);
      chk("pwm_low1", p + 1 - d, k);
      lvl(2, 1'b1, k);
      chk("pwm_duty2", w, k);
      end_sim();
   end
endmodule // tb_timer_channel_array
